/* bench/pter_root_model.sv */
`timescale 1ns/1ps
`default_nettype none

// --------
// Root side: counts every error message pulse it receives.
// --------
module pter_root_model (
	input  wire logic  clk_i,
	input  wire logic  rst_i,      // Power-on reset only, so counts survive hot reset.
	input  wire logic  msg_cor_i,
	input  wire logic  msg_nf_i,
	input  wire logic  msg_fatal_i,
	output logic [7:0] cor_cnt_o,
	output logic [7:0] nf_cnt_o,
	output logic [7:0] fatal_cnt_o
);
	// One pulse is one message; a held level would be counted as several.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cor_cnt_o   <= 8'h00;
			nf_cnt_o    <= 8'h00;
			fatal_cnt_o <= 8'h00;
		end else begin
			cor_cnt_o   <= cor_cnt_o + {7'h00, msg_cor_i};
			nf_cnt_o    <= nf_cnt_o + {7'h00, msg_nf_i};
			fatal_cnt_o <= fatal_cnt_o + {7'h00, msg_fatal_i};
		end
	end
endmodule // pter_root_model

`default_nettype wire

/* bench/pter_top_sva.sv */
`timescale 1ns/1ps
`default_nettype none

// --------
// Port checker for the error report block.
// --------
module pter_top_sva
	import pter_pkg::*;
(
	input wire logic        clk_i,
	input wire logic        srst_i,
	input wire logic        por_srst_i,
	input wire logic        ce_i,
	input wire logic        psel_i,
	input wire logic        penable_i,
	input wire logic        pwrite_i,
	input wire logic [11:0] paddr_i,
	input wire logic [31:0] prdata_o,
	input wire logic        pready_o,
	input wire logic        pslverr_o,
	input wire logic        parity_err_i,
	input wire logic        posted_age_drop_i,
	input wire logic        nonposted_age_drop_i,
	input wire logic        completion_age_drop_i,
	input wire logic        inserted_age_drop_i,
	input wire logic        msg_cor_o,
	input wire logic        msg_nonfatal_o,
	input wire logic        msg_fatal_o
);
	// Decoded helpers keep each property short.
	wire logic acc = psel_i && penable_i;
	wire logic hit = paddr_i inside {PTER_PCHK_OFS, PTER_PAR_STS_OFS, PTER_PAR_CTL_OFS,
		PTER_PAR_CNT_OFS, PTER_TO_STS_OFS, PTER_TO_CTL_OFS};
	wire logic rd  = acc && !pwrite_i && ce_i;
	wire logic msg = msg_cor_o || msg_nonfatal_o || msg_fatal_o;
	wire logic evt = parity_err_i || posted_age_drop_i || nonposted_age_drop_i
		|| completion_age_drop_i || inserted_age_drop_i;

	default clocking @(posedge clk_i); endclocking
	default disable iff (srst_i || por_srst_i);

	// Two count reads back to back: the second must see the cleared value.
	sequence s_cnt_rd; rd && paddr_i == PTER_PAR_CNT_OFS; endsequence
	sequence s_cnt_setup;
		psel_i && !penable_i && !pwrite_i && ce_i && paddr_i == PTER_PAR_CNT_OFS;
	endsequence
	property p_cnt_clr; s_cnt_rd ##1 s_cnt_setup |=> prdata_o[7:0] == 8'h00; endproperty
	property p_msg_cause; msg |-> $past(evt); endproperty
	property p_rst_quiet; disable iff (por_srst_i) srst_i |=> !msg; endproperty
	property p_sts_rsvd; rd && paddr_i == PTER_PAR_STS_OFS |-> prdata_o[31:1] == 31'h0; endproperty
	property p_cnt_rsvd; rd && paddr_i == PTER_PAR_CNT_OFS |-> prdata_o[31:8] == 24'h0; endproperty
	property p_unm_zero; rd && !hit |-> prdata_o == 32'h0000_0000; endproperty
	property p_slv_bad; acc && !hit |-> pslverr_o; endproperty
	property p_slv_ok; acc && hit |-> !pslverr_o && pready_o; endproperty

	a_cnt_clr: assert property (p_cnt_clr) else $error("Count not cleared by read.");
	a_msg_cause: assert property (p_msg_cause) else $error("Message without event.");
	a_rst_quiet: assert property (p_rst_quiet) else $error("Message after reset.");
	a_sts_rsvd: assert property (p_sts_rsvd) else $error("Status reserved bits set.");
	a_cnt_rsvd: assert property (p_cnt_rsvd) else $error("Count above bit 7.");
	a_unm_zero: assert property (p_unm_zero) else $error("Unmapped read not zero.");
	a_slv_bad: assert property (p_slv_bad) else $error("Unmapped access accepted.");
	a_slv_ok: assert property (p_slv_ok) else $error("Mapped access refused.");
endmodule // pter_top_sva

bind pter_top pter_top_sva u_sva (.clk_i(clk_i), .srst_i(srst_i), .por_srst_i(por_srst_i),
	.ce_i(ce_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
	.paddr_i(paddr_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
	.parity_err_i(parity_err_i), .posted_age_drop_i(posted_age_drop_i),
	.nonposted_age_drop_i(nonposted_age_drop_i), .completion_age_drop_i(completion_age_drop_i),
	.inserted_age_drop_i(inserted_age_drop_i), .msg_cor_o(msg_cor_o),
	.msg_nonfatal_o(msg_nonfatal_o), .msg_fatal_o(msg_fatal_o));

`default_nettype wire

/* bench/pter_top_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none

module pter_top_tb_top
	import pter_pkg::*;
;
	logic        clk_i = 1'b0, srst_i = 1'b1, por_srst_i = 1'b1, ce_i = 1'b1;
	logic        psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0, chained = 1'b0;
	logic [11:0] paddr_i = 12'h000;
	logic [31:0] pwdata_i = 32'h0000_0000, prdata_o, rdat;
	logic        pready_o, pslverr_o, rerr, m_c, m_n, m_f;
	logic [4:0]  ev = 5'h00;        // Parity, posted, non-posted, completion, inserted.
	logic [7:0]  n_c, n_n, n_f, x_c = 8'h00, x_n = 8'h00, x_f = 8'h00;
	int          num_errors = 0, samples_checked = 0, cyc = 0, i, s;

	pter_top uut (.clk_i(clk_i), .srst_i(srst_i), .por_srst_i(por_srst_i), .ce_i(ce_i),
		.psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
		.pwdata_i(pwdata_i), .pstrb_i(4'hf), .prdata_o(prdata_o), .pready_o(pready_o),
		.pslverr_o(pslverr_o), .parity_err_i(ev[0]), .posted_age_drop_i(ev[1]),
		.nonposted_age_drop_i(ev[2]), .completion_age_drop_i(ev[3]),
		.inserted_age_drop_i(ev[4]), .msg_cor_o(m_c), .msg_nonfatal_o(m_n), .msg_fatal_o(m_f));
	pter_root_model root (.clk_i(clk_i), .rst_i(por_srst_i), .msg_cor_i(m_c), .msg_nf_i(m_n),
		.msg_fatal_i(m_f), .cor_cnt_o(n_c), .nf_cnt_o(n_n), .fatal_cnt_o(n_f));

	// --------
	// Clock, and a cycle ceiling well above the few hundred cycles used.
	// --------
	always #20 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 3000) begin
			num_errors++;
			give_verdict();
		end
	end

	task give_verdict;
		$display("Checks %0d, mismatches %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task chk(input logic [31:0] g, input logic [31:0] e);
		samples_checked++;
		if (g !== e) begin
			num_errors++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
		end
	endtask

	// One APB transfer; with nx set the next setup follows at once, so psel stays up.
	task xfer(input logic w, input logic [11:0] a, input logic [31:0] d, input logic nx);
		if (!chained) @(posedge clk_i);
		psel_i   <= 1'b1;
		pwrite_i <= w;
		paddr_i  <= a;
		pwdata_i <= d;
		@(posedge clk_i);
		penable_i <= 1'b1;
		do @(posedge clk_i); while (pready_o !== 1'b1);
		rdat = prdata_o;
		rerr = pslverr_o;
		penable_i <= 1'b0;
		if (!nx) psel_i <= 1'b0;
		chained = nx;
	endtask

	task wr(input logic [11:0] a, input logic [31:0] d);
		xfer(1'b1, a, d, 1'b0);
	endtask

	task rd(input logic [11:0] a, input logic [7:0] e);
		xfer(1'b0, a, 32'h0000_0000, 1'b0);
		chk(rdat, {24'h00_0000, e});
	endtask

	// Event pulse, then two edges so the message has reached the root model.
	task pulse(input logic [4:0] v);
		@(posedge clk_i);
		ev <= v;
		@(posedge clk_i);
		ev <= 5'h00;
		repeat (2) @(posedge clk_i);
	endtask

	task bump(input int sv);
		case (sv)
			1: x_c++;
			2: x_n++;
			3: x_f++;
			default: ;
		endcase
	endtask

	task cmsg;
		chk({8'h00, n_c, n_n, n_f}, {8'h00, x_c, x_n, x_f});
	endtask

	// --------
	// Main sequence.
	// --------
	initial begin
		repeat (3) @(posedge clk_i);
		srst_i     <= 1'b0;
		por_srst_i <= 1'b0;
		rd(PTER_PAR_STS_OFS, 8'h00);
		rd(PTER_PAR_CTL_OFS, 8'h02);
		rd(PTER_PAR_CNT_OFS, 8'h00);
		rd(PTER_TO_STS_OFS, 8'h00);
		rd(PTER_TO_CTL_OFS, 8'h82);
		rd(12'h750, 8'h00);
		chk({31'h0, rerr}, 32'h0000_0001);
		// Each severity once; the second error while the flag is set stays silent.
		for (s = 0; s < 4; s++) begin
			wr(PTER_PAR_CTL_OFS, s);
			pulse(5'h01);
			bump(s);
			pulse(5'h01);
			cmsg();
			rd(PTER_PAR_STS_OFS, 8'h01);
			wr(PTER_PAR_STS_OFS, 32'h0000_0001);
			rd(PTER_PAR_STS_OFS, 8'h00);
		end
		xfer(1'b0, PTER_PAR_CNT_OFS, 32'h0000_0000, 1'b1);
		chk(rdat, 32'h0000_0008);
		rd(PTER_PAR_CNT_OFS, 8'h00);
		// Errors held for more cycles than the count can hold.
		wr(PTER_PAR_CTL_OFS, 32'h0000_0000);
		@(posedge clk_i);
		ev <= 5'h01;
		repeat (300) @(posedge clk_i);
		ev <= 5'h00;
		rd(PTER_PAR_CNT_OFS, 8'hff);
		wr(PTER_PAR_STS_OFS, 32'h0000_0001);
		// Checking disabled, then clock enable low: neither may record an error.
		wr(PTER_PCHK_OFS, 32'h0000_0001);
		pulse(5'h01);
		wr(PTER_PCHK_OFS, 32'h0000_0000);
		@(posedge clk_i);
		ce_i <= 1'b0;
		pulse(5'h01);
		ce_i <= 1'b1;
		rd(PTER_PAR_STS_OFS, 8'h00);
		rd(PTER_PAR_CNT_OFS, 8'h00);
		// Time-outs, each queue with a different severity.
		wr(PTER_TO_CTL_OFS, 32'h0000_00e4);
		for (i = 0; i < 4; i++) begin
			pulse(5'h02 << i);
			bump((8'he4 >> (2 * i)) & 3);
			cmsg();
			rd(PTER_TO_STS_OFS, 8'((2 << i) - 1));
		end
		wr(PTER_TO_STS_OFS, 32'h0000_000f);
		rd(PTER_TO_STS_OFS, 8'h00);
		// Hot reset clears flags but keeps sticky fields.
		wr(PTER_PAR_CTL_OFS, 32'h0000_0003);
		pulse(5'h01);
		bump(3);
		cmsg();
		pulse(5'h02);
		cmsg();
		@(posedge clk_i);
		srst_i <= 1'b1;
		@(posedge clk_i);
		srst_i <= 1'b0;
		rd(PTER_PAR_STS_OFS, 8'h00);
		rd(PTER_TO_STS_OFS, 8'h00);
		rd(PTER_PAR_CTL_OFS, 8'h02);
		rd(PTER_PAR_CNT_OFS, 8'h01);
		rd(PTER_TO_CTL_OFS, 8'he4);
		give_verdict();
	end
endmodule // pter_top_tb_top

`default_nettype wire

/* verilog/pter_flag.sv */
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// Sticky W1C flag with rising-edge report pulse.
// ----------------------------------------------------------------
module pter_flag (
	input  wire logic clk_i,
	input  wire logic srst_i,
	input  wire logic en_i,
	input  wire logic set_i,
	input  wire logic clr_i,
	output logic      flag_o,
	output logic      rise_o
);

	logic flag_ff;   // Flag state.

	// Set wins over a clear in the same cycle so no event is lost.
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			flag_ff <= 1'b0;
		end else if (en_i) begin
			if (set_i) begin
				flag_ff <= 1'b1;
			end else if (clr_i) begin
				flag_ff <= 1'b0;
			end
		end
	end

	// A report is due only when the flag goes from zero to one.
	assign rise_o = en_i & set_i & ~flag_ff;
	assign flag_o = flag_ff;

endmodule // pter_flag

`default_nettype wire

/* verilog/pter_pkg.sv */
package pter_pkg;

	// ----------------------------------------------------------------
	// Register byte offsets
	// ----------------------------------------------------------------
	localparam logic [11:0] PTER_PAR_STS_OFS  = 12'h0744; // Parity status.
	localparam logic [11:0] PTER_PAR_CTL_OFS  = 12'h0748; // Parity report control.
	localparam logic [11:0] PTER_PAR_CNT_OFS  = 12'h074c; // Parity count.
	localparam logic [11:0] PTER_PCHK_OFS     = 12'h0740; // Parity check disable.
	localparam logic [11:0] PTER_TO_STS_OFS   = 12'h0754; // Time-out status.
	localparam logic [11:0] PTER_TO_CTL_OFS   = 12'h0758; // Time-out report control.

	// ----------------------------------------------------------------
	// Field positions and reset values
	// ----------------------------------------------------------------
	localparam int          PTER_PAR_FLAG_BIT  = 0;        // Parity flag bit.
	localparam int          PTER_PCHK_BIT      = 0;        // Disable bit.
	localparam int          PTER_POSTED_BIT    = 0;        // Posted time-out bit.
	localparam int          PTER_NONPOSTED_BIT = 1;        // Non-posted bit.
	localparam int          PTER_COMPL_BIT     = 2;        // Completion bit.
	localparam int          PTER_INSERT_BIT    = 3;        // Inserted bit.
	localparam logic [1:0]  PTER_PAR_SEV_RST   = 2'h2;     // Parity severity reset.
	localparam logic [7:0]  PTER_TO_SEV_RST    = 8'h82;    // 7:6=2,5:4=0,3:2=0,1:0=2.
	localparam logic [7:0]  PTER_CNT_MAX       = 8'hff;    // Saturation value.

	// ----------------------------------------------------------------
	// Severity encoding
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		PTER_SEV_NONE     = 2'b00,
		PTER_SEV_COR      = 2'b01,
		PTER_SEV_NONFATAL = 2'b10,
		PTER_SEV_FATAL    = 2'b11
	} pter_sev_t;

endpackage

/* verilog/pter_sat_cnt.sv */
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// Saturating counter, cleared by a read.
// ----------------------------------------------------------------
module pter_sat_cnt
	import pter_pkg::*;
#(
	parameter int W = 8
) (
	input  wire logic         clk_i,
	input  wire logic         srst_i,    // Sticky: only power-on reset.
	input  wire logic         en_i,
	input  wire logic         inc_i,
	input  wire logic         rd_clr_i,
	output logic [W-1:0]      cnt_o
);

	logic [W-1:0] cnt_ff;   // Count value.

	// An increment in the read cycle is lost by design: the read returned
	// the old value and clears, the same trade a single-port tally makes.
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			cnt_ff <= '0;
		end else if (en_i) begin
			if (rd_clr_i) begin
				cnt_ff <= '0;
			end else if (inc_i && (cnt_ff != {W{1'b1}})) begin
				cnt_ff <= cnt_ff + 1'b1;
			end
		end
	end

	assign cnt_o = cnt_ff;

endmodule // pter_sat_cnt

`default_nettype wire

/* verilog/pter_top.sv */
// Behaviour
// - Parity error sets status bit zero, W1C.
// - Parity severity two bits, reset nonfatal.
// - Report parity only on zero-to-one rise.
// - Eight-bit parity count saturates at FF.
// - Reading parity count clears it.
// - Posted age drop sets bit zero.
// - Non-posted age drop sets bit one.
// - Completion age drop sets bit two.
// - Inserted age drop sets bit three.
// - Posted severity bits 1:0, reset nonfatal.
// - Non-posted severity bits 3:2, reset none.
// - Completion severity bits 5:4, reset none.
// - Inserted severity bits 7:6, reset nonfatal.
// - Check disable keeps parity events from flag and count.
`timescale 1ns/1ps
`default_nettype none

module pter_top
	import pter_pkg::*;
(
	input  wire logic        clk_i,          // 25 MHz core clock.
	input  wire logic        srst_i,         // Hot reset, keeps sticky fields.
	input  wire logic        por_srst_i,     // Power-on reset, clears everything.
	input  wire logic        ce_i,           // Clock enable; low freezes state.
	// APB slave.
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [11:0] paddr_i,
	input  wire logic [31:0] pwdata_i,
	input  wire logic [3:0]  pstrb_i,
	output logic [31:0]      prdata_o,
	output logic             pready_o,
	output logic             pslverr_o,
	// Error events, one-cycle pulses.
	input  wire logic        parity_err_i,
	input  wire logic        posted_age_drop_i,
	input  wire logic        nonposted_age_drop_i,
	input  wire logic        completion_age_drop_i,
	input  wire logic        inserted_age_drop_i,
	// Error message request toward the root.
	output logic             msg_cor_o,
	output logic             msg_nonfatal_o,
	output logic             msg_fatal_o
);

	// ----------------------------------------------------------------
	// Bus decode
	// ----------------------------------------------------------------
	logic        acc;          // Access phase, one cycle, zero waits.
	logic        wr;           // Write taking effect.
	logic        rd;           // Read taking effect.
	logic        hit;          // Mapped address.
	logic        sts_wr;       // Write of parity status.
	logic        tsts_wr;      // Write of time-out status.
	logic        cnt_rd;       // Read of parity count.

	assign acc    = psel_i & penable_i & ce_i;
	assign wr     = acc & pwrite_i;
	assign rd     = acc & ~pwrite_i;

	// Address decode as an if chain.
	always_comb begin
		hit = 1'b0;
		if (paddr_i == PTER_PCHK_OFS) begin
			hit = 1'b1;
		end else if (paddr_i == PTER_PAR_STS_OFS) begin
			hit = 1'b1;
		end else if (paddr_i == PTER_PAR_CTL_OFS) begin
			hit = 1'b1;
		end else if (paddr_i == PTER_PAR_CNT_OFS) begin
			hit = 1'b1;
		end else if (paddr_i == PTER_TO_STS_OFS) begin
			hit = 1'b1;
		end else if (paddr_i == PTER_TO_CTL_OFS) begin
			hit = 1'b1;
		end
	end

	assign sts_wr  = wr & pstrb_i[0] & (paddr_i == PTER_PAR_STS_OFS);
	assign tsts_wr = wr & pstrb_i[0] & (paddr_i == PTER_TO_STS_OFS);
	assign cnt_rd  = rd & (paddr_i == PTER_PAR_CNT_OFS);

	// Zero wait states; unmapped addresses answer with an error.
	assign pready_o  = 1'b1;
	assign pslverr_o = psel_i & penable_i & ~hit;

	// ----------------------------------------------------------------
	// Control registers (sticky, power-on reset only, except parity severity)
	// ----------------------------------------------------------------
	logic       pchk_dis_ff;   // Parity check disable.
	logic [1:0] par_sev_ff;    // Parity severity.
	logic [7:0] to_sev_ff;     // Four time-out severities.

	// Sticky fields survive a hot reset; only power-on clears them.
	always_ff @(posedge clk_i) begin
		if (por_srst_i) begin
			pchk_dis_ff <= 1'b0;
			to_sev_ff   <= PTER_TO_SEV_RST;
		end else if (wr && pstrb_i[0]) begin
			if (paddr_i == PTER_PCHK_OFS) begin
				pchk_dis_ff <= pwdata_i[PTER_PCHK_BIT];
			end else if (paddr_i == PTER_TO_CTL_OFS) begin
				to_sev_ff <= pwdata_i[7:0];
			end
		end
	end

	// The parity severity is not sticky, so either reset returns it to
	// nonfatal; software must program it again after a hot reset.
	always_ff @(posedge clk_i) begin
		if (srst_i || por_srst_i) begin
			par_sev_ff <= PTER_PAR_SEV_RST;
		end else if (wr && pstrb_i[0] && (paddr_i == PTER_PAR_CTL_OFS)) begin
			par_sev_ff <= pwdata_i[1:0];
		end
	end

	// ----------------------------------------------------------------
	// Status flags
	// ----------------------------------------------------------------
	logic       par_set;        // Qualified parity event.
	logic       any_rst;        // Either reset clears non-sticky state.
	logic       par_flag;       // Parity flag.
	logic       par_rise;       // Parity flag rising.
	logic [3:0] to_set;         // Time-out events.
	logic [3:0] to_flag;        // Time-out flags.
	logic [3:0] to_rise;        // Time-out flags rising.
	logic [7:0] par_cnt;        // Parity count.

	// Disabled checking means no parity event reaches flag or count.
	assign par_set = parity_err_i & ~pchk_dis_ff;
	assign any_rst = srst_i | por_srst_i;

	assign to_set[PTER_POSTED_BIT]    = posted_age_drop_i;
	assign to_set[PTER_NONPOSTED_BIT] = nonposted_age_drop_i;
	assign to_set[PTER_COMPL_BIT]     = completion_age_drop_i;
	assign to_set[PTER_INSERT_BIT]    = inserted_age_drop_i;

	// Parity status flag, W1C.
	pter_flag u_par_flag (
		.clk_i  (clk_i),
		.srst_i (any_rst),
		.en_i   (ce_i),
		.set_i  (par_set),
		.clr_i  (sts_wr & pwdata_i[PTER_PAR_FLAG_BIT]),
		.flag_o (par_flag),
		.rise_o (par_rise)
	);

	// Four time-out flags, one module each.
	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_to
			pter_flag u_to_flag (
				.clk_i  (clk_i),
				.srst_i (any_rst),
				.en_i   (ce_i),
				.set_i  (to_set[g]),
				.clr_i  (tsts_wr & pwdata_i[g]),
				.flag_o (to_flag[g]),
				.rise_o (to_rise[g])
			);
		end
	endgenerate

	// Parity count is sticky, so of the two resets only power-on clears it; a count read also clears it.
	pter_sat_cnt #(
		.W (8)
	) u_par_cnt (
		.clk_i    (clk_i),
		.srst_i   (por_srst_i),
		.en_i     (ce_i),
		.inc_i    (par_set),
		.rd_clr_i (cnt_rd),
		.cnt_o    (par_cnt)
	);

	// ----------------------------------------------------------------
	// Error message generation
	// ----------------------------------------------------------------
	logic [2:0] nxt_msg;     // Bit 0 cor, 1 nonfatal, 2 fatal.
	logic [2:0] msg_ff;      // Registered message pulses.

	// Each rising flag asks for the message its severity names.
	always_comb begin
		nxt_msg = 3'b000;
		if (par_rise) begin
			case (pter_sev_t'(par_sev_ff))
				PTER_SEV_COR:      nxt_msg[0] = 1'b1;
				PTER_SEV_NONFATAL: nxt_msg[1] = 1'b1;
				PTER_SEV_FATAL:    nxt_msg[2] = 1'b1;
				default:           nxt_msg = nxt_msg;
			endcase
		end
		for (int i = 0; i < 4; i++) begin
			if (to_rise[i]) begin
				case (pter_sev_t'(to_sev_ff[2*i +: 2]))
					PTER_SEV_COR:      nxt_msg[0] = 1'b1;
					PTER_SEV_NONFATAL: nxt_msg[1] = 1'b1;
					PTER_SEV_FATAL:    nxt_msg[2] = 1'b1;
					default:           nxt_msg = nxt_msg;
				endcase
			end
		end
	end

	// Messages are one-cycle pulses after the rising event.
	always_ff @(posedge clk_i) begin
		if (any_rst) begin
			msg_ff <= 3'b000;
		end else if (ce_i) begin
			msg_ff <= nxt_msg;
		end
	end

	assign msg_cor_o      = msg_ff[0];
	assign msg_nonfatal_o = msg_ff[1];
	assign msg_fatal_o    = msg_ff[2];

	// ----------------------------------------------------------------
	// Read data
	// ----------------------------------------------------------------
	logic [31:0] nxt_rdata;   // Read mux.
	logic [31:0] rdata_ff;    // Registered read data.

	// Reserved bits read zero; unmapped reads return zero.
	always_comb begin
		nxt_rdata = 32'h0000_0000;
		if (paddr_i == PTER_PCHK_OFS) begin
			nxt_rdata[PTER_PCHK_BIT] = pchk_dis_ff;
		end else if (paddr_i == PTER_PAR_STS_OFS) begin
			nxt_rdata[PTER_PAR_FLAG_BIT] = par_flag;
		end else if (paddr_i == PTER_PAR_CTL_OFS) begin
			nxt_rdata[1:0] = par_sev_ff;
		end else if (paddr_i == PTER_PAR_CNT_OFS) begin
			nxt_rdata[7:0] = par_cnt;
		end else if (paddr_i == PTER_TO_STS_OFS) begin
			nxt_rdata[3:0] = to_flag;
		end else if (paddr_i == PTER_TO_CTL_OFS) begin
			nxt_rdata[7:0] = to_sev_ff;
		end
	end

	// Data is captured in the setup cycle so it is stable in access phase;
	// the count read returns the pre-clear value that way.
	always_ff @(posedge clk_i) begin
		if (any_rst) begin
			rdata_ff <= 32'h0000_0000;
		end else if (ce_i && psel_i && !penable_i) begin
			rdata_ff <= nxt_rdata;
		end
	end

	assign prdata_o = rdata_ff;

endmodule // pter_top

`default_nettype wire
